// >>> rtl/adc_ctrl_pkg.sv
/*
 * constants for the converter start control block: register offsets,
 * field positions, reset values and status layout.
 * assumes a byte-wide register port with an 8-bit address.
 */
package adc_ctrl_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h01;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h02;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int unsigned POWER_BIT = 0;
    localparam int unsigned START_BIT = 1;
    localparam int unsigned CHAN_LSB = 2;
    localparam int unsigned CHAN_W = 4;
    localparam int unsigned NUM_INPUTS = 16;
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam logic [3:0] SMALL_LIMIT = 4'hc;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ************************************************************
    // interrupt status bits
    // ************************************************************
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_W = 1;
    localparam logic [0:0] IRQ_RESET = 1'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY
    } conv_state_e;

endpackage

// >>> rtl/adc_start_ctrl.sv
/*
 * converter start control: control register, start/busy handshake with
 * the converter core, power enable, channel route and done interrupt.
 * assumes a converter core on clk that pulses done after each start.
 */
// Notes on behaviour
// - while powered, selector codes 0 to 15 route analog inputs 0 to 15
// - on the small variant, codes 12 to 15 route no input
// - writing one to bit 1 together with one to bit 0 starts converting the selected channel
// - start bit stays one while converting, hardware clears on completion
// - start bit reads zero whenever no conversion runs
// - bit 0 powers the converter; zero shuts it off
// - bits 7:6 read zero; selector occupies bits 5:2
`timescale 1ns/10ps
module adc_start_ctrl
(
    input wire logic clk, // 50 MHz clock
    input wire logic reset_n, // async reset, active low
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] reg_addr, // register address
    input wire logic [adc_ctrl_pkg::DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [adc_ctrl_pkg::DATA_W-1:0] reg_rdata, // read data, next cycle
    input wire logic small_variant, // strap: twelve-input variant
    input wire logic core_done, // converter core completion pulse
    output logic [3:0] core_chan, // channel code to core
    output logic [15:0] core_route, // one-hot analog input route
    output logic core_start, // one-cycle start request
    output logic core_power, // converter power enable
    output logic irq // level interrupt
);
    import adc_ctrl_pkg::*;

    core_link_if link ();

    conv_state_e state_ff, nxt_state;
    logic [3:0] chan_ff, nxt_chan;
    logic power_ff, nxt_power;
    logic start_ff, nxt_start;
    logic [15:0] route_ff, nxt_route;
    logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
    logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
    logic irq_ff, nxt_irq;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic strap_s1_ff, strap_s2_ff;
    logic done_s1_ff, done_s2_ff, done_s3_ff;
    logic done_evt;
    logic [3:0] wr_chan;

    // ************************************************************
    // synchronisers for strap and core completion
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
            done_s3_ff <= 1'b0;
        end
        else
        begin
            strap_s1_ff <= small_variant;
            strap_s2_ff <= strap_s1_ff;
            done_s1_ff <= core_done;
            done_s2_ff <= done_s1_ff;
            done_s3_ff <= done_s2_ff;
        end
    end

    assign done_evt = done_s2_ff && !done_s3_ff;
    assign wr_chan = reg_wdata[CHAN_LSB +: CHAN_W];

    // ************************************************************
    // channel decoder
    // ************************************************************
    assign link.chan_code = chan_ff;
    assign link.small_variant = strap_s2_ff;

    chan_decode u_dec
    (
        .link(link)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // a code names a present input unless the small variant lacks it
    function automatic logic present(input logic [3:0] c, input logic s);
        return !(s && (c >= SMALL_LIMIT));
    endfunction

    // ************************************************************
    // control and conversion sequence
    // ************************************************************
    always_comb
    begin
        nxt_state = state_ff;
        nxt_chan = chan_ff;
        nxt_power = power_ff;
        nxt_start = 1'b0;
        if (reg_wr && hit(reg_addr, OFS_CONTROL))
        begin
            nxt_chan = wr_chan;
            nxt_power = reg_wdata[POWER_BIT];
        end
        unique case (state_ff)
            ST_IDLE:
            begin
                // start needs power and a present channel; the channel
                // judged is the one written together with the start bit
                if (reg_wr && hit(reg_addr, OFS_CONTROL) &&
                    reg_wdata[START_BIT] && reg_wdata[POWER_BIT] &&
                    present(wr_chan, strap_s2_ff))
                begin
                    nxt_state = ST_BUSY;
                    nxt_start = 1'b1;
                end
            end
            ST_BUSY:
            begin
                if (done_evt || !power_ff)
                begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
        // route only a powered and present channel
        nxt_route = '0;
        if (power_ff && link.chan_valid)
        begin
            nxt_route = link.chan_onehot;
        end
    end

    // ************************************************************
    // interrupt status and mask
    // ************************************************************
    always_comb
    begin
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_stat = irq_stat_ff;
        if (reg_wr && hit(reg_addr, OFS_IRQ_MASK))
        begin
            nxt_irq_mask = reg_wdata[IRQ_W-1:0];
        end
        if (reg_wr && hit(reg_addr, OFS_IRQ_STATUS))
        begin
            nxt_irq_stat = irq_stat_ff & ~reg_wdata[IRQ_W-1:0];
        end
        // set after clear so a completion in the clearing cycle wins
        if ((state_ff == ST_BUSY) && done_evt)
        begin
            nxt_irq_stat[IRQ_DONE_BIT] = 1'b1;
        end
        nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_stat_ff <= IRQ_RESET;
            irq_mask_ff <= IRQ_RESET;
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= nxt_irq;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_comb
    begin
        nxt_rdata = ZERO_BYTE;
        if (reg_rd)
        begin
            if (hit(reg_addr, OFS_CONTROL))
            begin
                nxt_rdata[CHAN_LSB +: CHAN_W] = chan_ff;
                nxt_rdata[START_BIT] = (state_ff == ST_BUSY);
                nxt_rdata[POWER_BIT] = power_ff;
            end
            else if (hit(reg_addr, OFS_IRQ_STATUS))
            begin
                nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
            end
            else if (hit(reg_addr, OFS_IRQ_MASK))
            begin
                nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= ST_IDLE;
            chan_ff <= CHAN_RESET;
            power_ff <= 1'b0;
            start_ff <= 1'b0;
            route_ff <= '0;
            rdata_ff <= ZERO_BYTE;
        end
        else
        begin
            state_ff <= nxt_state;
            chan_ff <= nxt_chan;
            power_ff <= nxt_power;
            start_ff <= nxt_start;
            route_ff <= nxt_route;
            rdata_ff <= nxt_rdata;
        end
    end

    assign core_start = start_ff;
    assign core_chan = chan_ff;
    assign core_power = power_ff;
    assign core_route = route_ff;
    assign irq = irq_ff;
    assign reg_rdata = rdata_ff;
endmodule

// >>> rtl/chan_decode.sv
/*
 * channel decoder: turns the 4-bit selector into a one-hot input route.
 * assumes the small-variant strap is a stable level.
 */
`timescale 1ns/10ps
module chan_decode
(
    core_link_if.dec link // selector in, route out
);
    import adc_ctrl_pkg::*;

    // ************************************************************
    // decode
    // ************************************************************
    always_comb
    begin
        link.chan_valid = !(link.small_variant &&
            (link.chan_code >= SMALL_LIMIT));
        link.chan_onehot = '0;
        if (link.chan_valid)
        begin
            link.chan_onehot[link.chan_code] = 1'b1;
        end
    end
endmodule

// >>> rtl/core_link_if.sv
/*
 * carrier between the control block and its channel decoder.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/10ps
interface core_link_if;
    logic [3:0] chan_code;
    logic small_variant;
    logic [15:0] chan_onehot;
    logic chan_valid;

    modport ctrl
    (
        output chan_code,
        output small_variant,
        input chan_onehot,
        input chan_valid
    );
    modport dec
    (
        input chan_code,
        input small_variant,
        output chan_onehot,
        output chan_valid
    );
endinterface

// >>> tb/adc_ctrl_assertions.sv
/* port checker for the converter start control.
   assumes it is bound into adc_start_ctrl. */
`timescale 1ns/10ps
module adc_ctrl_checker
(
    input wire logic clk, // clock
    input wire logic reset_n, // reset
    input wire logic [7:0] reg_addr, // address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write
    input wire logic reg_rd, // read
    input wire logic [7:0] reg_rdata, // read data
    input wire logic small_variant, // strap
    input wire logic core_done, // done
    input wire logic [3:0] core_chan, // channel
    input wire logic [15:0] core_route, // route
    input wire logic core_start, // start
    input wire logic core_power // power
);
    import adc_ctrl_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence ctl_wr;
        reg_wr && reg_addr == OFS_CONTROL;
    endsequence
    sequence ctl_rd;
        reg_rd && reg_addr == OFS_CONTROL;
    endsequence
    AST_START_ONE: assert property (core_start |=> !core_start)
        else $error("start too long");
    AST_START_CAUSE: assert property (core_start |->
        $past(reg_wr && reg_addr == OFS_CONTROL && reg_wdata[1:0] == 2'b11))
        else $error("start without write");
    AST_POWER: assert property (ctl_wr |=>
        core_power == $past(reg_wdata[POWER_BIT])) else $error("power");
    AST_ROUTE: assert property (core_start && core_power && !small_variant
        ##1 $stable(core_chan) && core_power |-> core_route == 16'h1 << core_chan)
        else $error("route");
    AST_SMALL: assert property (ctl_wr ##0 (small_variant &&
        $past(small_variant, 2) && reg_wdata[5:2] >= SMALL_LIMIT) |=> !core_start)
        else $error("small start");
    AST_TOP_ZERO: assert property (ctl_rd |=> reg_rdata[7:6] == 2'b00)
        else $error("top bits");
    AST_BUSY_READ: assert property (core_start ##0 ctl_rd |=> reg_rdata[1])
        else $error("busy read");
    AST_IDLE_READ: assert property ($rose(core_done) ##4 ctl_rd |=>
        !reg_rdata[START_BIT]) else $error("idle read");
endmodule
bind adc_start_ctrl adc_ctrl_checker u_chk (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .small_variant(small_variant),
    .core_done(core_done), .core_chan(core_chan), .core_route(core_route),
    .core_start(core_start), .core_power(core_power));

// >>> tb/core_model.sv
/* converter core stand-in: answers each start with one done pulse while powered.
   assumes start is a one-cycle pulse on clk. */
`timescale 1ns/10ps
module core_model
(
    input wire logic clk, // clock
    input wire logic reset_n, // reset
    input wire logic core_start, // start pulse
    input wire logic core_power, // power
    input wire logic [7:0] lat, // wait cycles
    output logic core_done // done pulse
);
    logic [8:0] cnt_ff;
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_ff <= 9'h000;
            core_done <= 1'b0;
        end
        else
        begin
            core_done <= core_power && cnt_ff == 9'h001;
            if (!core_power)
                cnt_ff <= 9'h000;
            else if (core_start)
                cnt_ff <= {1'b0, lat} + 9'h001;
            else if (cnt_ff != 9'h000)
                cnt_ff <= cnt_ff - 9'h001;
        end
    end
endmodule

// >>> tb/tb_adc_channel_start_control.sv
/* self-checking bench for adc_start_ctrl with a core stand-in.
   assumes the checker file binds itself in. */
`timescale 1ns/10ps
module tb_adc_channel_start_control;
    import adc_ctrl_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic small_variant = 1'b0, core_start, core_power, core_done, irq;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, lat = 8'h00;
    logic [7:0] reg_rdata, d;
    logic [3:0] core_chan;
    logic [15:0] core_route;
    logic [31:0] lfsr = 32'hcb47ade0;
    int n_mismatch = 0, cmp_count = 0, cycles = 0;
    always #10 clk = ~clk;
    adc_start_ctrl DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .small_variant(small_variant),
        .core_done(core_done), .core_chan(core_chan), .core_route(core_route),
        .core_start(core_start), .core_power(core_power), .irq(irq));
    core_model u_core (.clk(clk), .reset_n(reset_n), .core_start(core_start),
        .core_power(core_power), .lat(lat), .core_done(core_done));
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_ctl(logic [3:0] c, logic g, logic p);
        return {2'b00, c, g, p};
    endfunction
    function automatic logic [15:0] exp_route(logic [3:0] c, logic s);
        return (s && c >= SMALL_LIMIT) ? 16'h0000 : 16'h0001 << c;
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_data(logic [7:0] got, logic [7:0] exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask
    task automatic chk_bit(logic got, logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic results;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [7:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // one conversion with random wait and random junk in bits 7:6
    task automatic conv(logic [3:0] ch);
        lfsr = lfsr_next(lfsr);
        lat <= lfsr[7:0] & 8'h3f;
        wr(OFS_CONTROL, {lfsr[9:8], ch, 2'b11});
        rd(OFS_CONTROL);
        chk_data(d, exp_ctl(ch, 1'b1, 1'b1));
        chk(core_route, exp_route(ch, small_variant));
        chk_data({4'h0, core_chan}, {4'h0, ch});
        for (int i = 0; i < 200 && d[START_BIT]; i++)
            rd(OFS_CONTROL);
        chk_data(d, exp_ctl(ch, 1'b0, 1'b1));
        rd(OFS_IRQ_STATUS);
        chk_data(d, 8'h01);
        chk_bit(irq, ch[0]);
        wr(OFS_IRQ_STATUS, 8'h01);
        rd(OFS_IRQ_STATUS);
        chk_data(d, 8'h00);
        chk_bit(irq, 1'b0);
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_mismatch++;
            results();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        wr(8'h05, 8'hff);
        for (int a = 0; a < 6; a++)
        begin
            rd(a[7:0]);
            chk_data(d, ZERO_BYTE);
        end
        for (int c = 0; c < 16; c++)
        begin
            wr(OFS_IRQ_MASK, {7'h00, c[0]});
            conv(c[3:0]);
        end
        small_variant <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        for (int c = 12; c < 16; c++)
        begin
            wr(OFS_CONTROL, {2'b00, c[3:0], 2'b11});
            rd(OFS_CONTROL);
            chk_data(d, exp_ctl(c[3:0], 1'b0, 1'b1));
            chk(core_route, exp_route(c[3:0], 1'b1));
        end
        conv(4'hb);
        small_variant <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        wr(OFS_CONTROL, 8'h0a);
        rd(OFS_CONTROL);
        chk_data(d, exp_ctl(4'h2, 1'b0, 1'b0));
        chk(core_route, 16'h0000);
        lat <= 8'hff;
        wr(OFS_CONTROL, 8'h0b);
        wr(OFS_CONTROL, 8'h08);
        repeat (300) @(posedge clk);
        #1;
        rd(OFS_IRQ_STATUS);
        chk_data(d, 8'h00);
        results();
    end
endmodule
